/* File: core/sbs_pkg.sv */
// package: register map, field positions, reset values and state types of the break/sync serial block
package sbs_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;  // control bits
  localparam logic [7:0]  OFS_BAUD   = 8'h04;  // baud divisor
  localparam logic [7:0]  OFS_TXDATA = 8'h08;  // tx_holding_reg, write only
  localparam logic [7:0]  OFS_STATUS = 8'h0C;  // flags, read only
  localparam logic [7:0]  OFS_RXDATA = 8'h10;  // rx_holding_reg, read clears flags

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_W    = 11;
  localparam int unsigned C_TRANSMIT_ENABLE    = 0;   // transmit_enable
  localparam int unsigned C_BRK     = 1;   // break_request
  localparam int unsigned C_SYNC    = 2;   // clocked_mode_select
  localparam int unsigned C_CLOCK_SOURCE_MASTER    = 3;   // clock_source_master
  localparam int unsigned C_PORT_ENABLE    = 4;   // port_enable
  localparam int unsigned C_SINGLE_RECEIVE_ENABLE    = 5;   // single_receive_enable
  localparam int unsigned C_CONTINUOUS_RECEIVE_ENABLE    = 6;   // continuous_receive_enable
  localparam int unsigned C_CLOCK_IDLE_POLARITY    = 7;   // clock_idle_polarity
  localparam int unsigned C_TX9     = 8;   // nine_bit_transmit
  localparam int unsigned C_NINTH_TX_BIT    = 9;   // ninth_tx_bit
  localparam int unsigned C_WUE     = 10;  // wake_on_break

  // status register fields
  localparam int unsigned S_SHIFT_EMPTY_FLAG    = 0;   // shift_empty_flag
  localparam int unsigned S_TX_HOLDING_EMPTY_FLAG    = 1;   // tx_holding_empty_flag
  localparam int unsigned S_RX_AVAILABLE_FLAG    = 2;   // rx_available_flag
  localparam int unsigned S_FRAMING_ERROR_FLAG    = 3;   // framing_error_flag

  // ---------------------------------------------------------------
  // reset values and frame shapes
  // ---------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST  = 11'h000;
  localparam logic [15:0]       DIV_RST   = 16'h000F;   // half bit = divisor+1 clocks
  localparam logic [13:0]       BRK_FRAME = 14'h2000;   // start, twelve zeros, stop
  localparam logic [3:0]        BRK_BITS  = 4'hE;
  localparam logic [3:0]        ASY_BITS8 = 4'hA;
  localparam logic [3:0]        ASY_BITS9 = 4'hB;
  localparam logic [3:0]        SYN_BITS8 = 4'h8;
  localparam logic [3:0]        SYN_BITS9 = 4'h9;
  localparam logic [2:0]        RX_LAST   = 3'h7;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} sbs_txst_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11} sbs_rxst_t;

  typedef struct packed {
    logic data_out;
    logic data_oe;
    logic clk_out;
    logic clk_oe;
  } sbs_pins_t;

  localparam sbs_pins_t PINS_RST = '{data_out: 1'b1, data_oe: 1'b0, clk_out: 1'b1, clk_oe: 1'b0};

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic [CTRL_W-1:0] ctrl;
    logic [15:0]       div;
    logic [7:0]        hold;
    logic              hold_full;
    logic              hold_brk;
    logic              hold_9;
    sbs_txst_t         tx;
    logic [13:0]       sh;
    logic [3:0]        nbits;
    logic              brk;
    logic [15:0]       tcnt;
    logic              tph;
    logic              shift_empty_flag;
    logic              tx_holding_empty_flag;
    sbs_rxst_t         rx;
    logic [16:0]       rcnt;
    logic [2:0]        ridx;
    logic [7:0]        rsh;
    logic [7:0]        rdata;
    logic              rx_available_flag;
    logic              framing_error_flag;
    logic              rx_m;
    logic              rx_s;
    logic              rx_d;
    sbs_pins_t         pins;
  } sbs_state_t;

endpackage : sbs_pkg

/* File: core/sbs_serial.sv */
// module: break and clocked-master transmitter with break receiver, APB register slave
//
// Function
// - break is start, twelve zeros, stop
// - tx write with break set sends zeros
// - hardware clears break_request after stop bit
// - next character waits, sent after break
// - shift_empty_flag tracks break like characters
// - tx_holding_empty_flag sets when holding empties
// - received break sets both flags, data zero
// - wake: falling edge event, then next byte
// - clocked mode sends no start/stop bits
// - clocked mode half duplex, one data line
// - master when mode, source, enable set
// - transmit only with both receive enables clear
// - master drives clock pin, driver auto-enabled
// - one clock cycle per data bit only
// - polarity selects idle level and change edge
// - master transmit enables data and clock drivers
// - new character waits for previous last bit
// - empty shift register loads character at once
// - data changes on leading edge, held
// - wake_on_break cleared on break-ending rise
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
module sbs_serial
  import sbs_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // serial pins
  input  wire logic              data_line_i,
  output logic                   data_line_o,
  output logic                   data_line_oe,
  output logic                   clock_line_o,
  output logic                   clock_line_oe
);

  // ---------------------------------------------------------------
  // state and decode helpers
  // ---------------------------------------------------------------
  sbs_state_t s_r, s_nxt;
  logic       acc, wr, rd, mst, mst_tx, tx_go, rx_en, wake_on;
  logic       bit_end, last_bit, load, fall, rise, wr_ctrl;

  // outputs straight from the state flops
  assign prdata        = s_r.prdata;
  assign pready        = s_r.pready;
  assign pslverr       = s_r.pslverr;
  assign data_line_o   = s_r.pins.data_out;
  assign data_line_oe  = s_r.pins.data_oe;
  assign clock_line_o  = s_r.pins.clk_out;
  assign clock_line_oe = s_r.pins.clk_oe;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt   = s_r;
    // data line synchroniser, first stage feeds only the second
    s_nxt.rx_m = data_line_i;
    s_nxt.rx_s = s_r.rx_m;
    s_nxt.rx_d = s_r.rx_s;
    fall    = s_r.rx_d & ~s_r.rx_s;
    rise    = ~s_r.rx_d & s_r.rx_s;

    // mode decode
    mst     = s_r.ctrl[C_PORT_ENABLE] & s_r.ctrl[C_SYNC] & s_r.ctrl[C_CLOCK_SOURCE_MASTER];
    mst_tx  = mst & ~s_r.ctrl[C_SINGLE_RECEIVE_ENABLE] & ~s_r.ctrl[C_CONTINUOUS_RECEIVE_ENABLE];
    tx_go   = s_r.ctrl[C_TRANSMIT_ENABLE] & (mst_tx | (s_r.ctrl[C_PORT_ENABLE] & ~s_r.ctrl[C_SYNC]));
    rx_en   = s_r.ctrl[C_PORT_ENABLE] & ~s_r.ctrl[C_SYNC] & s_r.ctrl[C_CONTINUOUS_RECEIVE_ENABLE];
    wake_on = s_r.ctrl[C_PORT_ENABLE] & ~s_r.ctrl[C_SYNC] & s_r.ctrl[C_WUE];

    // apb: access phase answered one cycle later, then taken
    acc     = psel & penable;
    wr      = acc & s_r.pready & pwrite;
    rd      = acc & s_r.pready & ~pwrite;
    wr_ctrl = wr & (paddr == OFS_CTRL);
    s_nxt.pready  = acc & ~s_r.pready;
    s_nxt.pslverr = 1'b0;
    if (acc & ~s_r.pready) begin
      s_nxt.prdata = 32'h0000_0000;
      if (paddr == OFS_CTRL) begin
        s_nxt.prdata[CTRL_W-1:0] = s_r.ctrl;
      end else if (paddr == OFS_BAUD) begin
        s_nxt.prdata[15:0] = s_r.div;
      end else if (paddr == OFS_STATUS) begin
        s_nxt.prdata[S_SHIFT_EMPTY_FLAG] = s_r.shift_empty_flag;
        s_nxt.prdata[S_TX_HOLDING_EMPTY_FLAG] = s_r.tx_holding_empty_flag;
        s_nxt.prdata[S_RX_AVAILABLE_FLAG] = s_r.rx_available_flag;
        s_nxt.prdata[S_FRAMING_ERROR_FLAG] = s_r.framing_error_flag;
      end else if (paddr == OFS_RXDATA) begin
        s_nxt.prdata[7:0] = s_r.rdata;
      end else if (paddr != OFS_TXDATA) begin
        s_nxt.pslverr = 1'b1;                   // unmapped address
      end
    end

    // reading received data clears its flags; a set below wins
    if (rd && paddr == OFS_RXDATA) begin
      s_nxt.rx_available_flag = 1'b0;
      s_nxt.framing_error_flag = 1'b0;
    end

    // transmitter: half-bit timer, two halves per bit
    bit_end  = (s_r.tx == TX_SHIFT) & (s_r.tcnt == 16'h0000) & s_r.tph;
    last_bit = (s_r.nbits == 4'h1);
    load     = 1'b0;
    case (s_r.tx)
      TX_IDLE: begin
        if (tx_go && s_r.hold_full) begin
          load = 1'b1;
        end
      end
      TX_SHIFT: begin
        if (!tx_go) begin
          s_nxt.tx = TX_IDLE;                   // disabled mid-character: abandon it
        end else if (s_r.tcnt != 16'h0000) begin
          s_nxt.tcnt = s_r.tcnt - 16'h0001;
        end else if (!s_r.tph) begin
          s_nxt.tph  = 1'b1;                    // trailing half of the bit
          s_nxt.tcnt = s_r.div;
        end else if (last_bit) begin
          s_nxt.tx = TX_IDLE;
          if (s_r.brk) begin
            s_nxt.ctrl[C_BRK] = 1'b0;
          end
          if (s_r.hold_full) begin
            load = 1'b1;
          end
        end else begin
          s_nxt.sh    = {1'b0, s_r.sh[13:1]};
          s_nxt.nbits = s_r.nbits - 4'h1;
          s_nxt.tph   = 1'b0;
          s_nxt.tcnt  = s_r.div;
        end
      end
      default: s_nxt.tx = TX_IDLE;
    endcase

    // move holding register into the shift register
    if (load) begin
      s_nxt.tx        = TX_SHIFT;
      s_nxt.hold_full = 1'b0;
      s_nxt.tx_holding_empty_flag      = 1'b1;
      s_nxt.brk       = s_r.hold_brk;
      s_nxt.tph       = 1'b0;
      s_nxt.tcnt      = s_r.div;
      if (s_r.ctrl[C_SYNC]) begin
        s_nxt.sh    = {5'h00, s_r.hold_9, s_r.hold};
        s_nxt.nbits = s_r.ctrl[C_TX9] ? SYN_BITS9 : SYN_BITS8;
      end else if (s_r.hold_brk) begin
        s_nxt.sh    = BRK_FRAME;
        s_nxt.nbits = BRK_BITS;
      end else if (s_r.ctrl[C_TX9]) begin
        s_nxt.sh    = {3'h0, 1'b1, s_r.hold_9, s_r.hold, 1'b0};
        s_nxt.nbits = ASY_BITS9;
      end else begin
        s_nxt.sh    = {4'h0, 1'b1, s_r.hold, 1'b0};
        s_nxt.nbits = ASY_BITS8;
      end
    end

    // write into the holding register, ignored while it is full
    if (wr && paddr == OFS_TXDATA && !s_r.hold_full) begin
      s_nxt.hold      = pwdata[7:0];
      s_nxt.hold_full = 1'b1;
      // a byte queued behind a running break is an ordinary character
      s_nxt.hold_brk  = s_r.ctrl[C_BRK] & s_r.ctrl[C_TRANSMIT_ENABLE] & ~s_r.ctrl[C_SYNC]
                        & ~((s_r.tx == TX_SHIFT) & s_r.brk);
      s_nxt.hold_9    = s_r.ctrl[C_NINTH_TX_BIT];
      s_nxt.tx_holding_empty_flag      = 1'b0;
    end
    s_nxt.shift_empty_flag = (s_nxt.tx == TX_IDLE);

    // receiver: start checked at half bit, data sampled mid-bit
    if (!rx_en && !wake_on) begin
      s_nxt.rx = RX_IDLE;
    end else begin
      case (s_r.rx)
        RX_IDLE: begin
          if (wake_on) begin
            if (fall) begin
              s_nxt.rx_available_flag = 1'b1;
            end
            if (rise) begin
              s_nxt.ctrl[C_WUE] = 1'b0;
            end
          end else if (fall) begin
            s_nxt.rx   = RX_START;
            s_nxt.rcnt = {1'b0, s_r.div};
          end
        end
        RX_START: begin
          if (s_r.rcnt != 17'h00000) begin
            s_nxt.rcnt = s_r.rcnt - 17'h00001;
          end else if (!s_r.rx_s) begin
            s_nxt.rx   = RX_DATA;
            s_nxt.rcnt = {s_r.div, 1'b1};
            s_nxt.ridx = 3'h0;
          end else begin
            s_nxt.rx = RX_IDLE;                 // glitch, not a start bit
          end
        end
        RX_DATA: begin
          if (s_r.rcnt != 17'h00000) begin
            s_nxt.rcnt = s_r.rcnt - 17'h00001;
          end else begin
            s_nxt.rsh  = {s_r.rx_s, s_r.rsh[7:1]};
            s_nxt.rcnt = {s_r.div, 1'b1};
            s_nxt.ridx = s_r.ridx + 3'h1;
            if (s_r.ridx == RX_LAST) begin
              s_nxt.rx = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (s_r.rcnt != 17'h00000) begin
            s_nxt.rcnt = s_r.rcnt - 17'h00001;
          end else begin
            s_nxt.rdata = s_r.rsh;
            s_nxt.rx_available_flag  = 1'b1;
            s_nxt.framing_error_flag  = ~s_r.rx_s;
            s_nxt.rx    = RX_IDLE;
          end
        end
        default: s_nxt.rx = RX_IDLE;
      endcase
    end

    // software writes to control land last so a set beats a hardware clear
    if (wr_ctrl) begin
      s_nxt.ctrl = pwdata[CTRL_W-1:0];
    end
    if (wr && paddr == OFS_BAUD) begin
      s_nxt.div = pwdata[15:0];
    end

    // pins: clocked master drives the clock line, and the data line only in transmit; async drives tx on the clock line
    if (s_r.ctrl[C_SYNC]) begin
      s_nxt.pins.clk_oe   = mst;
      s_nxt.pins.clk_out  = s_r.ctrl[C_CLOCK_IDLE_POLARITY] ^ ((s_nxt.tx == TX_SHIFT) & ~s_nxt.tph);
      s_nxt.pins.data_oe  = mst_tx & s_r.ctrl[C_TRANSMIT_ENABLE];
      s_nxt.pins.data_out = (s_nxt.tx == TX_SHIFT) ? s_nxt.sh[0] : 1'b1;
    end else begin
      s_nxt.pins.clk_oe   = s_r.ctrl[C_PORT_ENABLE] & s_r.ctrl[C_TRANSMIT_ENABLE];
      s_nxt.pins.clk_out  = (s_nxt.tx == TX_SHIFT) ? s_nxt.sh[0] : 1'b1;
      s_nxt.pins.data_oe  = 1'b0;
      s_nxt.pins.data_out = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r           <= '0;
      s_r.ctrl      <= CTRL_RST;
      s_r.div       <= DIV_RST;
      s_r.tx        <= TX_IDLE;
      s_r.rx        <= RX_IDLE;
      s_r.shift_empty_flag      <= 1'b1;
      s_r.tx_holding_empty_flag      <= 1'b1;
      s_r.rx_m      <= 1'b1;
      s_r.rx_s      <= 1'b1;
      s_r.rx_d      <= 1'b1;
      s_r.pins      <= PINS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_break_frame: assert property (load && s_r.hold_brk && !s_r.ctrl[C_SYNC]
    |=> s_r.nbits == 4'hE && s_r.sh == 14'h2000 && s_r.brk)
    else $error("break frame not loaded as fourteen bits");
  a_break_zeros: assert property (s_r.tx == TX_SHIFT && s_r.brk && s_r.nbits > 4'h1
    |-> s_r.sh[0] == 1'b0)
    else $error("break sends a one before its stop bit");
  a_break_clear: assert property (bit_end && last_bit && s_r.brk && tx_go && !wr_ctrl
    |=> !s_r.ctrl[C_BRK])
    else $error("break_request not cleared after stop bit");
  a_queue_follow: assert property (bit_end && last_bit && tx_go && s_r.hold_full
    |=> s_r.tx == TX_SHIFT && !s_r.hold_full && s_r.tx_holding_empty_flag)
    else $error("queued character not started after previous one");
  a_shift_empty_flag_busy: assert property (s_r.tx == TX_SHIFT |-> !s_r.shift_empty_flag ##1 (s_r.tx == TX_SHIFT || s_r.shift_empty_flag))
    else $error("shift_empty_flag disagrees with transmitter");
  a_hold_wait: assert property (s_r.hold_full && s_r.tx == TX_SHIFT && !(bit_end && last_bit)
    |=> s_r.hold_full)
    else $error("holding register emptied mid-character");
  a_idle_load: assert property (s_r.tx == TX_IDLE && tx_go && s_r.hold_full
    |=> s_r.tx == TX_SHIFT ##0 s_r.tx_holding_empty_flag)
    else $error("character not moved into empty shift register");
  a_rx_break: assert property (rx_en && s_r.rx == RX_STOP && s_r.rcnt == 17'h00000
    && s_r.rsh == 8'h00 && !s_r.rx_s |=> s_r.rx_available_flag && s_r.framing_error_flag && s_r.rdata == 8'h00)
    else $error("received break not flagged");
  a_wake_clear: assert property (wake_on && s_r.rx == RX_IDLE && rise && !wr_ctrl
    |=> !s_r.ctrl[C_WUE])
    else $error("wake_on_break not cleared on rising edge");
  a_sync_bits: assert property (load && s_r.ctrl[C_SYNC] |=> s_r.nbits <= 4'h9)
    else $error("clocked character carries framing bits");
  a_half_duplex: assert property (s_r.pins.data_oe
    |-> !$past(s_r.ctrl[C_SINGLE_RECEIVE_ENABLE]) && !$past(s_r.ctrl[C_CONTINUOUS_RECEIVE_ENABLE]))
    else $error("data line driven while receive enabled");
  a_clk_idle: assert property (s_r.tx == TX_IDLE && $past(mst)
    |-> s_r.pins.clk_out == $past(s_r.ctrl[C_CLOCK_IDLE_POLARITY]) && s_r.pins.clk_oe)
    else $error("master clock not at idle level");

  c_break_done: cover property (bit_end && last_bit && s_r.brk && s_r.hold_full);
  c_sync_char: cover property (load && s_r.ctrl[C_SYNC]);
  c_rx_break: cover property (s_r.rx_available_flag && s_r.framing_error_flag && s_r.rdata == 8'h00);
  c_wake: cover property (wake_on && rise);

endmodule : sbs_serial

/* File: sim/sbs_far_node.sv */
// far-side node model: clocked slave capture and async receive-line driver
`timescale 1ns/1ps
module sbs_far_node
  import sbs_pkg::*;
(
  // system clock
  input  wire logic        clk,
  // line levels seen on the wire
  input  wire logic        line_clk,
  input  wire logic        line_data,
  input  wire logic        idle_pol,
  // receive-line drive and captured bits
  output logic             rx_drv,
  output logic [15:0]      cap,
  output int               ncap
);
  logic prev_clk;

  initial begin
    rx_drv   = 1'b1;
    cap      = 16'h0000;
    ncap     = 0;
    prev_clk = 1'b0;
  end

  // a slave samples data on the trailing edge, where the master holds it stable
  always @(posedge clk) begin
    prev_clk <= line_clk;
    if (prev_clk !== idle_pol && line_clk === idle_pol) begin
      cap  <= {line_data, cap[15:1]};
      ncap <= ncap + 1;
    end
  end

  // async frame, lsb first, one link bit per 8 clocks (320 ns); pull-up idle after
  task automatic send(input logic [13:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rx_drv <= bits[i];
      repeat (8) @(posedge clk);
    end
    rx_drv <= 1'b1;
  endtask : send
endmodule : sbs_far_node

/* File: sim/sbs_serial_tb.sv */
// testbench for the break/sync serial block
`timescale 1ns/1ps
module sbs_serial_tb
  import sbs_pkg::*;
;
  localparam logic [31:0] MST = (32'h1 << C_TRANSMIT_ENABLE) | (32'h1 << C_SYNC) | (32'h1 << C_CLOCK_SOURCE_MASTER) | (32'h1 << C_PORT_ENABLE);
  localparam logic [31:0] RXC = (32'h1 << C_PORT_ENABLE) | (32'h1 << C_CONTINUOUS_RECEIVE_ENABLE);

  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata, rd;
  logic              pready, pslverr, err, pol_r = 1'b0;
  logic              data_line_o, data_line_oe, clock_line_o, clock_line_oe, rx_drv, data_wire;
  logic [15:0]       cap;
  int                ncap;
  int                error_cnt = 0;
  int                n_tests = 0;

  // clock and shared data wire
  always #20 clk = ~clk;
  assign data_wire = data_line_oe ? data_line_o : rx_drv;

  sbs_serial i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_line_i(data_wire), .data_line_o(data_line_o), .data_line_oe(data_line_oe),
    .clock_line_o(clock_line_o), .clock_line_oe(clock_line_oe));

  sbs_far_node i_far (.clk(clk), .line_clk(clock_line_oe ? clock_line_o : pol_r), .line_data(data_wire),
    .idle_pol(pol_r), .rx_drv(rx_drv), .cap(cap), .ncap(ncap));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // look at pready where it is settled, then complete on the next rising edge
    do begin
      @(negedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    psel    <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1, "apb ready");
  endtask : xfer

  task automatic wait_flag(input logic [31:0] mask);
    int n;
    n = 0;
    do begin
      xfer(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while ((rd & mask) !== mask && n < 300);
    chk(rd & mask, mask, "status flag");
  endtask : wait_flag

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_reset();
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    xfer(1'b0, OFS_BAUD, 32'h0);
    chk(rd, 32'h0000000F, "baud reset");
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h3, "status reset");
    xfer(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("test reset done");
  endtask : test_reset

  task automatic test_break();
    logic [23:0] s;
    int n;
    xfer(1'b1, OFS_BAUD, 32'h3);
    xfer(1'b1, OFS_CTRL, (32'h1 << C_TRANSMIT_ENABLE) | (32'h1 << C_BRK) | (32'h1 << C_PORT_ENABLE));
    fork
      begin
        n = 0;
        while (clock_line_o !== 1'b0 && n < 500) begin
          @(posedge clk);
          n++;
        end
        repeat (4) @(posedge clk);
        for (int i = 0; i < 24; i++) begin
          s[i] = clock_line_o;
          repeat (8) @(posedge clk);
        end
      end
      begin
        xfer(1'b1, OFS_TXDATA, 32'hFF);
        wait_flag(32'h1 << S_TX_HOLDING_EMPTY_FLAG);
        xfer(1'b1, OFS_TXDATA, 32'h55);
        xfer(1'b0, OFS_STATUS, 32'h0);
        chk({31'h0, rd[S_SHIFT_EMPTY_FLAG]}, 32'h0, "busy during break");
        xfer(1'b0, OFS_CTRL, 32'h0);
        chk({31'h0, rd[C_BRK]}, 32'h1, "break bit held");
      end
    join
    chk({8'h0, s}, {8'h0, 1'b1, 8'h55, 1'b0, 1'b1, 13'h0}, "break then sync");
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk({31'h0, rd[C_BRK]}, 32'h0, "break bit cleared");
    repeat (8) @(posedge clk);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h3, "idle after header");
    $display("test break done");
  endtask : test_break

  task automatic test_clocked();
    int base;
    int n;
    for (int p = 0; p < 2; p++) begin
      pol_r <= p[0];
      xfer(1'b1, OFS_CTRL, MST | ({31'h0, p[0]} << C_CLOCK_IDLE_POLARITY));
      repeat (3) @(posedge clk);
      chk({29'h0, clock_line_oe, data_line_oe, clock_line_o}, {29'h0, 2'b11, p[0]}, "master pins");
      base = ncap;
      xfer(1'b1, OFS_TXDATA, 32'hA5);
      wait_flag(32'h1 << S_TX_HOLDING_EMPTY_FLAG);
      xfer(1'b1, OFS_TXDATA, 32'h3C);
      n = 0;
      while (ncap - base < 16 && n < 400) begin
        @(posedge clk);
        n++;
      end
      repeat (40) @(posedge clk);
      chk(ncap - base, 32'd16, "clock count");
      chk({16'h0, cap}, 32'h3CA5, "clocked data");
      chk({31'h0, clock_line_o}, {31'h0, p[0]}, "clock idle level");
    end
    // nine-bit clocked character: ninth bit loaded before the data write
    pol_r <= 1'b0;
    xfer(1'b1, OFS_CTRL, MST | (32'h1 << C_TX9) | (32'h1 << C_NINTH_TX_BIT));
    repeat (3) @(posedge clk);
    base = ncap;
    xfer(1'b1, OFS_TXDATA, 32'h5A);
    n = 0;
    while (ncap - base < 9 && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (40) @(posedge clk);
    chk(ncap - base, 32'd9, "nine bit clock count");
    chk({23'h0, cap[15:7]}, 32'h15A, "nine bit data");
    xfer(1'b1, OFS_CTRL, MST | (32'h1 << C_SINGLE_RECEIVE_ENABLE));
    repeat (3) @(posedge clk);
    chk({30'h0, clock_line_oe, data_line_oe}, 32'h2, "receive mode pins");
    xfer(1'b1, OFS_CTRL, MST & ~(32'h1 << C_PORT_ENABLE));
    repeat (3) @(posedge clk);
    chk({31'h0, clock_line_oe}, 32'h0, "port disabled");
    pol_r <= 1'b0;
    xfer(1'b1, OFS_CTRL, 32'h0);
    $display("test clocked done");
  endtask : test_clocked

  task automatic test_rx_break();
    xfer(1'b1, OFS_CTRL, RXC);
    i_far.send(14'h2000, 14);
    repeat (16) @(posedge clk);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'hF, "break flags");
    xfer(1'b0, OFS_RXDATA, 32'h0);
    chk(rd, 32'h0, "break data");
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h3, "flags cleared");
    $display("test rx break done");
  endtask : test_rx_break

  task automatic test_wake();
    xfer(1'b1, OFS_CTRL, RXC | (32'h1 << C_WUE));
    fork
      i_far.send(14'h2000, 14);
      begin
        repeat (20) @(posedge clk);
        xfer(1'b0, OFS_STATUS, 32'h0);
        chk({31'h0, rd[S_RX_AVAILABLE_FLAG]}, 32'h1, "wake event");
        xfer(1'b0, OFS_CTRL, 32'h0);
        chk({31'h0, rd[C_WUE]}, 32'h1, "wake held in break");
      end
    join
    repeat (6) @(posedge clk);
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk(rd, RXC, "wake cleared");
    xfer(1'b0, OFS_RXDATA, 32'h0);
    i_far.send({4'h0, 1'b1, 8'h5A, 1'b0}, 10);
    repeat (16) @(posedge clk);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h7, "byte after wake");
    xfer(1'b0, OFS_RXDATA, 32'h0);
    chk(rd, 32'h5A, "data after wake");
    $display("test wake done");
  endtask : test_wake

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    test_reset();
    test_break();
    test_clocked();
    test_rx_break();
    test_wake();
    conclude();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule : sbs_serial_tb
